// File: design/pec_error_checker.sv
// Error detection and classification for a PCI Express stack, with the
// root port interrupt reception paths and an AXI4-Lite register slave.
// Assumes the stack delivers per-packet check results in one cycle.
`timescale 1ns/100ps
`default_nettype none
module pec_error_checker #(
  parameter int LANES  = 4,
  parameter int EPUR_W = 8,
  parameter int RPUR_W = 4,
  parameter int UCPL_W = 5,
  parameter int MALF_W = 7
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [11:0]       s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic [LANES*3-1:0] lane_rxstatus,
  input  wire logic [LANES-1:0]  lane_in_l0,
  input  wire logic              deskew_ovf,
  input  wire logic              ctrl_sym_wrong_lane,
  input  wire logic              dllp_crc_bad,
  input  wire logic              replay_timeout,
  input  wire logic              replay_rollover,
  input  wire logic              ack_valid,
  input  wire logic [11:0]       acknowledge_sequence_value,
  input  wire logic [11:0]       ack_floor_seq,
  input  wire logic [11:0]       tx_last_seq,
  input  wire logic              dl_up,
  input  wire logic              fc_update_rx,
  input  wire logic              rx_valid,
  input  wire logic              rx_non_posted,
  input  wire logic              rx_fc_overflow,
  input  wire logic [MALF_W-1:0] rx_malformed,
  input  wire logic              rx_lcrc_bad,
  input  wire logic              rx_seq_bad,
  input  wire logic              rx_ecrc_bad,
  input  wire logic [EPUR_W-1:0] rx_ep_ur,
  input  wire logic              rx_mem_req,
  input  wire logic [RPUR_W-1:0] rx_rp_ur,
  input  wire logic [UCPL_W-1:0] rx_ucpl,
  input  wire logic              rx_poisoned,
  input  wire logic              rx_intx_msg,
  input  wire logic              rx_intx_assert,
  input  wire logic [1:0]        rx_intx_line,
  input  wire logic [2:0]        cpl_err,
  input  wire logic [4:0]        aer_msi_num,
  input  wire logic [4:0]        pex_msi_num,
  input  wire logic              pm_event,
  input  wire logic              err_msg_valid,
  input  wire logic [1:0]        err_msg_sev,
  output logic                   rx_forward,
  output logic                   rx_discard,
  output logic                   cpl_gen_valid,
  output logic                   cpl_gen_ur,
  output logic                   err_cor,
  output logic                   err_nonfatal,
  output logic                   err_fatal,
  output logic                   credit_update_timeout_fault,
  output logic [3:0]             int_status,
  output logic                   err_msi_valid,
  output logic [4:0]             err_msi_num,
  output logic                   pm_msi_valid,
  output logic [4:0]             pm_msi_num
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True for a lane status code that marks a receive port error.
  function automatic logic rx_port_err(input logic [2:0] c);
    rx_port_err = (c == pec_pkg::RXST_DECODE_ERR) || (c == pec_pkg::RXST_EB_OVF) ||
                  (c == pec_pkg::RXST_EB_UNF) || (c == pec_pkg::RXST_DISPARITY);
  endfunction

  // Byte enables widened to a bit mask.
  function automatic logic [31:0] bmask(input logic [3:0] s);
    bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [31:0] ctrl_reg, ctrl_next;
  logic [2:0]  errstat_reg, errstat_next;
  logic [6:0]  root_reg, root_next;
  logic [3:0]  intx_reg, intx_next;
  logic [11:0] fc_cnt_reg, fc_cnt_next;
  logic        fwd_reg, fwd_next, drop_reg, drop_next;
  logic        cpl_reg, cpl_next, cur_reg, cur_next;
  logic        cor_reg, cor_next, nf_reg, nf_next, fat_reg, fat_next, fcf_reg, fcf_next;
  logic        emsi_reg, emsi_next, pmsi_reg, pmsi_next;
  logic [4:0]  emsin_reg, emsin_next, pmsin_reg, pmsin_next;
  logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic        awg_reg, awg_next, wg_reg, wg_next;
  logic [11:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic        arr_reg, arr_next, rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;

  logic        rp_mode, aer_en, ep_ur_hit, ack_bad, phy_err, fc_fire;
  pec_pkg::pec_sev_t tlp_sev;

  assign rp_mode   = ctrl_reg[pec_pkg::CTRL_RP_BIT];
  assign aer_en    = ctrl_reg[pec_pkg::CTRL_AER_BIT];
  assign ep_ur_hit = (|rx_ep_ur) || (rx_mem_req && !ctrl_reg[pec_pkg::CTRL_MEMEN_BIT]);
  // Acknowledge must fall between the last acknowledged and last sent numbers.
  assign ack_bad   = ack_valid &&
                     ((12'(acknowledge_sequence_value - ack_floor_seq)) >
                      (12'(tx_last_seq - ack_floor_seq)));
  assign fc_fire   = dl_up && !fc_update_rx &&
                     (fc_cnt_reg == 12'(pec_pkg::FC_TIMEOUT_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Packet classification, severity pulses and interrupt paths.
  always_comb begin
    phy_err = deskew_ovf || ctrl_sym_wrong_lane;
    for (int i = 0; i < LANES; i++) begin
      phy_err = phy_err || (lane_in_l0[i] && rx_port_err(lane_rxstatus[i*3 +: 3]));
    end
    tlp_sev  = pec_pkg::SEV_NONE;
    fwd_next = 1'b0;
    drop_next = 1'b0;
    cpl_next = 1'b0;
    cur_next = cur_reg;
    intx_next = intx_reg;
    if (rx_valid) begin
      if (rx_fc_overflow) begin
        tlp_sev = pec_pkg::SEV_FAT;
        drop_next = 1'b1;
      end else if (|rx_malformed) begin
        tlp_sev = pec_pkg::SEV_FAT;
        drop_next = 1'b1;
      end else if (rx_lcrc_bad || rx_seq_bad) begin
        tlp_sev = pec_pkg::SEV_COR;
        drop_next = 1'b1;
      end else if (rx_ecrc_bad) begin
        tlp_sev = pec_pkg::SEV_NF;
        drop_next = 1'b1;
        cpl_next = rx_non_posted;
        cur_next = 1'b0;
      end else if (rp_mode && (|rx_rp_ur)) begin
        tlp_sev = pec_pkg::SEV_FAT;
        drop_next = 1'b1;
      end else if (!rp_mode && ep_ur_hit) begin
        tlp_sev = pec_pkg::SEV_NF;
        drop_next = 1'b1;
        cpl_next = rx_non_posted;
        cur_next = 1'b1;
      end else if (|rx_ucpl) begin
        tlp_sev = pec_pkg::SEV_NF;
        drop_next = 1'b1;
      end else if (rp_mode && rx_intx_msg) begin
        intx_next[rx_intx_line] = rx_intx_assert;
      end else begin
        fwd_next = 1'b1;
        if (rx_poisoned) begin
          tlp_sev = pec_pkg::SEV_NF;
        end
      end
    end
    cor_next = (tlp_sev == pec_pkg::SEV_COR) || phy_err || dllp_crc_bad ||
               replay_timeout || replay_rollover;
    nf_next  = (tlp_sev == pec_pkg::SEV_NF) || cpl_err[0] || cpl_err[2];
    fat_next = (tlp_sev == pec_pkg::SEV_FAT) || ack_bad || fc_fire;
    fcf_next = fc_fire;
    fc_cnt_next = (!dl_up || fc_update_rx || fc_fire) ? 12'h000 : 12'(fc_cnt_reg + 12'h001);
    pmsi_next = rp_mode && pm_event;
    pmsin_next = pm_event ? 5'(ctrl_reg[pec_pkg::CTRL_PMBASE_LSB +: 5] + pex_msi_num) : pmsin_reg;
    emsi_next = rp_mode && aer_en && err_msg_valid;
    emsin_next = err_msg_valid ? aer_msi_num : emsin_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register updates; hardware sets win over clears.
  always_comb begin
    logic [31:0] wm;
    logic        hit;
    logic [6:0]  rset;
    logic [6:0]  rclr;
    logic [2:0]  eclr;
    wm = bmask(ws_reg) & wd_reg;
    hit = 1'b0;
    rset = 7'h00;
    rclr = 7'h00;
    eclr = 3'h0;
    ctrl_next = ctrl_reg;
    awg_next = awg_reg;
    wg_next = wg_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    if (s_axi_awvalid && awr_reg) begin
      awg_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      wg_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (awg_reg && wg_reg && !bv_reg) begin
      awg_next = 1'b0;
      wg_next = 1'b0;
      bv_next = 1'b1;
      hit = 1'b1;
      case (awa_reg[11:2])
        pec_pkg::ADDR_CTRL[11:2]:     ctrl_next = (ctrl_reg & ~bmask(ws_reg)) | wm;
        pec_pkg::ADDR_ERRSTAT[11:2]:  eclr = wm[2:0];
        pec_pkg::ADDR_INTSTAT[11:2]:  hit = 1'b1;
        pec_pkg::ADDR_ROOTSTAT[11:2]: rclr = wm[6:0] & pec_pkg::RS_W1C_MASK;
        default:                      hit = 1'b0;
      endcase
      br_next = hit ? pec_pkg::RESP_OKAY : pec_pkg::RESP_SLVERR;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    awr_next = !awg_next && !bv_next;
    wr_next = !wg_next && !bv_next;
    // Root error status logging of received error messages.
    if (err_msg_valid && rp_mode) begin
      if (err_msg_sev == pec_pkg::MSG_COR) begin
        rset[pec_pkg::RS_COR] = 1'b1;
        rset[pec_pkg::RS_COR_MULT] = root_reg[pec_pkg::RS_COR];
      end else begin
        rset[pec_pkg::RS_UNC] = 1'b1;
        rset[pec_pkg::RS_UNC_MULT] = root_reg[pec_pkg::RS_UNC];
        rset[pec_pkg::RS_FIRST_FAT] = !root_reg[pec_pkg::RS_UNC] && (err_msg_sev == pec_pkg::MSG_FAT);
        rset[pec_pkg::RS_NF_RCVD] = (err_msg_sev == pec_pkg::MSG_NF);
        rset[pec_pkg::RS_FAT_RCVD] = (err_msg_sev == pec_pkg::MSG_FAT);
      end
    end
    root_next = (root_reg & ~rclr) | rset;
    errstat_next = (errstat_reg & ~eclr) | {fat_next, nf_next, cor_next};
    arr_next = arr_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_arvalid && arr_reg) begin
      arr_next = 1'b0;
      rv_next = 1'b1;
      rr_next = pec_pkg::RESP_OKAY;
      case (s_axi_araddr[11:2])
        pec_pkg::ADDR_CTRL[11:2]:     rd_next = ctrl_reg;
        pec_pkg::ADDR_ERRSTAT[11:2]:  rd_next = {29'h0, errstat_reg};
        pec_pkg::ADDR_INTSTAT[11:2]:  rd_next = {28'h0, intx_reg};
        pec_pkg::ADDR_ROOTSTAT[11:2]: rd_next = {aer_msi_num, 20'h0, root_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = pec_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
      arr_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; a low clock enable freezes everything except the synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= pec_pkg::CTRL_RESET;
      {errstat_reg, root_reg, intx_reg, fc_cnt_reg} <= '0;
      {fwd_reg, drop_reg, cpl_reg, cur_reg, cor_reg, nf_reg, fat_reg, fcf_reg} <= '0;
      {emsi_reg, pmsi_reg, emsin_reg, pmsin_reg} <= '0;
      {awr_reg, wr_reg, arr_reg} <= 3'h7;
      {bv_reg, awg_reg, wg_reg, rv_reg, br_reg, rr_reg} <= '0;
      {awa_reg, wd_reg, ws_reg, rd_reg} <= '0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      errstat_reg <= errstat_next;
      root_reg <= root_next;
      intx_reg <= intx_next;
      fc_cnt_reg <= fc_cnt_next;
      fwd_reg <= fwd_next;
      drop_reg <= drop_next;
      cpl_reg <= cpl_next;
      cur_reg <= cur_next;
      cor_reg <= cor_next;
      nf_reg <= nf_next;
      fat_reg <= fat_next;
      fcf_reg <= fcf_next;
      emsi_reg <= emsi_next;
      pmsi_reg <= pmsi_next;
      emsin_reg <= emsin_next;
      pmsin_reg <= pmsin_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      arr_reg <= arr_next;
      bv_reg <= bv_next;
      awg_reg <= awg_next;
      wg_reg <= wg_next;
      rv_reg <= rv_next;
      br_reg <= br_next;
      rr_reg <= rr_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      rd_reg <= rd_next;
    end
  end

  // Output drive, each straight from a flip-flop.
  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} = {awr_reg, wr_reg, bv_reg, br_reg};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {arr_reg, rv_reg, rd_reg, rr_reg};
  assign {rx_forward, rx_discard, cpl_gen_valid, cpl_gen_ur} = {fwd_reg, drop_reg, cpl_reg, cur_reg};
  assign {err_cor, err_nonfatal, err_fatal} = {cor_reg, nf_reg, fat_reg};
  assign credit_update_timeout_fault = fcf_reg;
  assign int_status = intx_reg;
  assign {err_msi_valid, err_msi_num, pm_msi_valid, pm_msi_num} = {emsi_reg, emsin_reg, pmsi_reg, pmsin_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic hi_clear;
  assign hi_clear = rx_valid && !rx_fc_overflow && !(|rx_malformed) && !rx_lcrc_bad && !rx_seq_bad;
  sequence s_wr_both;
    ce && awg_reg && wg_reg && !bv_reg;
  endsequence

  a_fc_timeout_fire: assert property (ce && fc_fire |=> credit_update_timeout_fault && err_fatal)
    else $error("credit timeout not raised");
  a_overflow_drop: assert property (ce && rx_valid && rx_fc_overflow |=> rx_discard && err_fatal && !rx_forward)
    else $error("overflow packet not deleted");
  a_ecrc_abort: assert property (ce && hi_clear && rx_ecrc_bad && rx_non_posted
      |=> cpl_gen_valid && !cpl_gen_ur && rx_discard && err_nonfatal)
    else $error("ecrc abort completion missing");
  a_ep_ur_cpl: assert property (ce && hi_clear && !rx_ecrc_bad && !rp_mode && ep_ur_hit && rx_non_posted
      |=> cpl_gen_valid && cpl_gen_ur && !err_fatal && rx_discard)
    else $error("endpoint unsupported request mishandled");
  a_rp_ur_fatal: assert property (ce && hi_clear && !rx_ecrc_bad && rp_mode && (|rx_rp_ur) |=> err_fatal && rx_discard)
    else $error("root unsupported request not fatal");
  a_poison_fwd: assert property (ce && hi_clear && !rx_ecrc_bad && !ep_ur_hit && !(|rx_rp_ur) && !(|rx_ucpl)
      && !rx_intx_msg && rx_poisoned |=> rx_forward && err_nonfatal)
    else $error("poisoned packet not forwarded");
  a_lcrc_cor: assert property (ce && rx_valid && !rx_fc_overflow && !(|rx_malformed) && rx_lcrc_bad
      |=> err_cor && rx_discard)
    else $error("bad packet not correctable");
  a_phy_cor: assert property (ce && lane_in_l0[0] && lane_rxstatus[2] |=> err_cor)
    else $error("lane error not flagged");
  a_ack_fatal: assert property (ce && ack_bad |=> err_fatal)
    else $error("bad acknowledge not fatal");
  a_intx_map: assert property (ce && hi_clear && !rx_ecrc_bad && rp_mode && !(|rx_rp_ur) && !(|rx_ucpl)
      && rx_intx_msg |=> int_status[$past(rx_intx_line)] == $past(rx_intx_assert) && !rx_forward)
    else $error("legacy interrupt status wrong");
  a_wr_resp: assert property (s_wr_both |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");

endmodule // pec_error_checker
`default_nettype wire

// File: design/pec_pkg.sv
// Constants shared by the error checker: register map, field positions,
// lane status codes and the credit update timeout.
// Assumes a 10 MHz application clock.
package pec_pkg;
  localparam logic [11:0] ADDR_CTRL     = 12'h800;
  localparam logic [11:0] ADDR_ERRSTAT  = 12'h804;
  localparam logic [11:0] ADDR_INTSTAT  = 12'h808;
  localparam logic [11:0] ADDR_ROOTSTAT = 12'h830;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int CTRL_RP_BIT     = 0;
  localparam int CTRL_AER_BIT    = 1;
  localparam int CTRL_MEMEN_BIT  = 2;
  localparam int CTRL_PMBASE_LSB = 8;
  localparam int ES_COR_BIT   = 0;
  localparam int ES_NF_BIT    = 1;
  localparam int ES_FAT_BIT   = 2;
  localparam int RS_COR       = 0;
  localparam int RS_COR_MULT  = 1;
  localparam int RS_UNC       = 2;
  localparam int RS_UNC_MULT  = 3;
  localparam int RS_FIRST_FAT = 4;
  localparam int RS_NF_RCVD   = 5;
  localparam int RS_FAT_RCVD  = 6;
  localparam int RS_MSI_LSB   = 27;
  localparam logic [6:0] RS_W1C_MASK = 7'h7f;
  localparam logic [2:0] RXST_DECODE_ERR = 3'h4;
  localparam logic [2:0] RXST_EB_OVF     = 3'h5;
  localparam logic [2:0] RXST_EB_UNF     = 3'h6;
  localparam logic [2:0] RXST_DISPARITY  = 3'h7;
  localparam logic [1:0] MSG_COR = 2'h0;
  localparam logic [1:0] MSG_NF  = 2'h1;
  localparam logic [1:0] MSG_FAT = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int FC_TIMEOUT_US  = 200;
  localparam int FC_TIMEOUT_CYC = FC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {SEV_NONE, SEV_COR, SEV_NF, SEV_FAT} pec_sev_t;
endpackage

// File: dv/pec_app_model.sv
// Application-side model: static MSI numbers, completion fault reports.
// Assumes the checker's aclk and its packet outcome pulses.
`timescale 1ns/100ps
`default_nettype none
module pec_app_model (
  input  wire logic       aclk,
  input  wire logic       rx_forward,
  output logic      [2:0] cpl_err,
  output logic      [4:0] aer_msi_num,
  output logic      [4:0] pex_msi_num
);
  int fwd_seen;
  // The MSI numbers are set once and never toggle.
  initial begin
    aer_msi_num = 5'h15;
    pex_msi_num = 5'h03;
    cpl_err = 3'h0;
    fwd_seen = 0;
  end
  // Forwarded packets, poisoned ones too, are taken and counted.
  always @(posedge aclk) if (rx_forward) fwd_seen++;
  // Reports one completion fault for one cycle.
  task automatic report(input int b);
    cpl_err[b] <= 1'h1;
    @(posedge aclk);
    cpl_err <= 3'h0;
  endtask
endmodule // pec_app_model
`default_nettype wire

// File: dv/pec_error_checker_tb.sv
// Self-checking bench: register bus tasks, packet and link event scenarios.
// Assumes the package and the application model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pec_error_checker_tb;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dl_up, fc_update_rx;
  logic        rx_valid, rx_non_posted, rx_fc_overflow, rx_ecrc_bad, rx_mem_req, rx_poisoned, rx_intx_msg;
  logic        rx_intx_assert, ack_valid, pm_event, err_msg_valid, rx_forward, rx_discard, cpl_gen_valid;
  logic        cpl_gen_ur, err_cor, err_nonfatal, err_fatal, credit_update_timeout_fault, err_msi_valid;
  logic        pm_msi_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rx_intx_line, err_msg_sev;
  logic [2:0]  cpl_err;
  logic [3:0]  s_axi_wstrb, lane_in_l0, rx_rp_ur, int_status;
  logic [4:0]  rx_ucpl, aer_msi_num, pex_msi_num, err_msi_num, pm_msi_num;
  logic [6:0]  rx_malformed, ev;
  logic [7:0]  rx_ep_ur;
  logic [11:0] s_axi_awaddr, s_axi_araddr, lane_rxstatus, acknowledge_sequence_value, ack_floor_seq, tx_last_seq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          err_count, checks_done;
  wire logic [5:0] o = {rx_forward, rx_discard, cpl_gen_valid, err_cor, err_nonfatal, err_fatal};
  // Clock at 10 MHz.
  always #50 aclk = ~aclk;
  pec_error_checker uut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .lane_rxstatus,
    .lane_in_l0, .deskew_ovf(ev[0]), .ctrl_sym_wrong_lane(ev[1]), .dllp_crc_bad(ev[2]), .replay_timeout(ev[3]),
    .replay_rollover(ev[4]), .rx_lcrc_bad(ev[5]), .rx_seq_bad(ev[6]), .ack_valid, .acknowledge_sequence_value,
    .ack_floor_seq, .tx_last_seq, .dl_up, .fc_update_rx, .rx_valid, .rx_non_posted, .rx_fc_overflow,
    .rx_malformed, .rx_ecrc_bad, .rx_ep_ur, .rx_mem_req, .rx_rp_ur, .rx_ucpl, .rx_poisoned, .rx_intx_msg,
    .rx_intx_assert, .rx_intx_line, .cpl_err, .aer_msi_num, .pex_msi_num, .pm_event, .err_msg_valid,
    .err_msg_sev, .rx_forward, .rx_discard, .cpl_gen_valid, .cpl_gen_ur, .err_cor, .err_nonfatal, .err_fatal,
    .credit_update_timeout_fault, .int_status, .err_msi_valid, .err_msi_num, .pm_msi_valid, .pm_msi_num);
  pec_app_model app (.aclk, .rx_forward, .cpl_err, .aer_msi_num, .pex_msi_num);
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and wait limit.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      err_count++;
      wrap_up();
    end
  endtask
  // Ends a one-cycle stimulus and compares the registered outcome.
  task automatic pk(input logic [5:0] e, input logic [5:0] m = 6'h3f);
    @(posedge aclk);
    {rx_valid, rx_non_posted, rx_fc_overflow, rx_ecrc_bad, rx_mem_req, rx_poisoned, rx_intx_msg, rx_intx_assert,
     ack_valid, pm_event, err_msg_valid, fc_update_rx, ev, rx_malformed, rx_ep_ur, rx_rp_ur, rx_ucpl,
     lane_rxstatus} <= '0;
    #1;
    chk(o & m, e);
  endtask
  // Register write and read; each channel is held until its ready.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    tmo(n);
    chk(s_axi_bresp, pec_pkg::RESP_OKAY);
  endtask
  task automatic rdr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = pec_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    tmo(n);
    chk({s_axi_rresp, s_axi_rdata}, {er, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    {aclk, aresetn, ce, s_axi_wstrb, err_count, checks_done} = {3'h1, 4'hf, 64'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, dl_up, rx_intx_line} = '0;
    {err_msg_sev, lane_in_l0, acknowledge_sequence_value, ack_floor_seq, tx_last_seq} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    pk(6'h00, 6'h00);
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(pec_pkg::ADDR_CTRL, pec_pkg::CTRL_RESET);
    rdr(12'h810, 32'h0, pec_pkg::RESP_SLVERR);
    // Lane codes in L0 and one outside it.
    for (int c = 4; c < 9; c++) begin
      @(posedge aclk);
      lane_in_l0 <= (c < 8) ? 4'h5 : 4'h0;
      lane_rxstatus <= (c < 8) ? 12'(c) << (6 * (c % 2)) : 12'h1c0;
      pk((c < 8) ? 6'h04 : 6'h00);
    end
    // Link events, then link CRC and sequence faults on a packet.
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      ev[i] <= 1'h1;
      rx_valid <= (i > 4);
      pk((i > 4) ? 6'h14 : 6'h04);
    end
    @(posedge aclk);
    {rx_valid, rx_ecrc_bad, rx_non_posted} <= 3'h7;
    pk(6'h1a);
    chk(cpl_gen_ur, 1'h0);
    @(posedge aclk);
    {rx_valid, rx_ecrc_bad} <= 2'h3;
    pk(6'h12);
    for (int i = 0; i < 9; i++) begin
      @(posedge aclk);
      {rx_valid, rx_non_posted, rx_ep_ur, rx_mem_req} <= {2'h3, 9'(1) << i};
      pk(6'h1a);
      chk(cpl_gen_ur, 1'h1);
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      {rx_valid, rx_malformed} <= {1'h1, 7'(1) << i};
      pk(6'h11);
      @(posedge aclk);
      {rx_valid, rx_ucpl} <= {1'h1, 5'(1) << (i % 5)};
      pk(6'h12);
    end
    @(posedge aclk);
    {rx_valid, rx_fc_overflow, rx_poisoned} <= 3'h7;
    pk(6'h11);
    @(posedge aclk);
    {rx_valid, rx_poisoned} <= 2'h3;
    pk(6'h22);
    // Acknowledge numbers across the wrap of the sequence space.
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      {ack_floor_seq, tx_last_seq, ack_valid} <= {24'hffe002, 1'h1};
      acknowledge_sequence_value <= i ? 12'h003 : 12'h001;
      pk(i ? 6'h01 : 6'h00);
    end
    for (int b = 0; b < 3; b += 2) begin
      @(posedge aclk);
      app.report(b);
      #1;
      chk(o, 6'h02);
    end
    rdr(pec_pkg::ADDR_ERRSTAT, 32'h7);
    wr(pec_pkg::ADDR_ERRSTAT, 32'h7);
    rdr(pec_pkg::ADDR_ERRSTAT, 32'h0);
    // Credit update timer with the link up and no updates.
    @(posedge aclk);
    dl_up <= 1'h1;
    for (n = 0; n < 2100 && credit_update_timeout_fault !== 1'h1; n++) @(posedge aclk);
    chk(n > 1990 && n < 2010, 1'h1);
    chk(err_fatal, 1'h1);
    dl_up <= 1'h0;
    // Root port mode with error messages enabled.
    wr(pec_pkg::ADDR_CTRL, 32'h1e03);
    rdr(pec_pkg::ADDR_CTRL, 32'h1e03);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      {rx_valid, rx_rp_ur} <= {1'h1, 4'(1) << i};
      pk(6'h11);
    end
    @(posedge aclk);
    rx_valid <= 1'h1;
    pk(6'h20);
    @(posedge aclk);
    {rx_valid, rx_intx_msg, rx_intx_assert, rx_intx_line} <= 5'h1e;
    pk(6'h00, 6'h20);
    chk(int_status, 4'h4);
    rdr(pec_pkg::ADDR_INTSTAT, 32'h4);
    @(posedge aclk);
    pm_event <= 1'h1;
    pk(6'h00, 6'h00);
    chk({pm_msi_valid, pm_msi_num}, 6'h21);
    @(posedge aclk);
    {err_msg_valid, err_msg_sev} <= 3'h5;
    pk(6'h00, 6'h00);
    chk({err_msi_valid, err_msi_num}, 6'h35);
    rdr(pec_pkg::ADDR_ROOTSTAT, {5'h15, 27'h24});
    wr(pec_pkg::ADDR_ROOTSTAT, 32'h7f);
    rdr(pec_pkg::ADDR_ROOTSTAT, {5'h15, 27'h0});
    chk(app.fwd_seen, 32'h2);
    wrap_up();
  end
endmodule // pec_error_checker_tb
`default_nettype wire
